/* File: design/nibble_alu.sv */
// Purpose: Four-bit ALU with zero, carry, compare and decimal flags.
// Assumes: One request per cycle; the sequencer acts on the answer next cycle.
// Notes: Flags are read and written as system-register nibbles.
`timescale 1ns/1ps
`include "nibble_alu_defines.svh"

module nibble_alu (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input nibble_alu_pkg::alu_req_t req_i,
  output nibble_alu_pkg::alu_res_t res_o,
  input nibble_alu_pkg::sysreg_req_t sysreg_i,
  output logic [3:0] sysreg_rdata_o,
  output logic index_enable_o
);
  import nibble_alu_pkg::*;

  logic zero_q;
  logic carry_q;
  logic compare_q;
  logic decimal_q;
  logic index_q;
  logic [3:0] rdata_q;
  alu_res_t res_q;

  logic [3:0] a_op;
  logic [3:0] b_op;
  logic is_arith;
  logic is_sub;
  logic use_carry;
  logic [4:0] arith_out;
  logic [4:0] cmp_out;
  logic [3:0] rot_out;
  logic arith_zero;
  logic mem_form;
  logic wr_status;

  // Adds or subtracts two nibbles with carry in; returns {carry or borrow, nibble}.
  function automatic logic [4:0] nibble_arith(input logic [3:0] a, input logic [3:0] b,
                                               input logic cin, input logic sub, input logic bcd);
    logic [4:0] raw;
    logic [4:0] adj;
    raw = 5'h00;
    adj = 5'h00;
    if (sub) begin
      raw = {1'b0, a} - {1'b0, b} - {4'h0, cin};
      adj = raw - `ALU_BCD_ADJUST;
      nibble_arith = (bcd && raw[4]) ? {1'b1, adj[3:0]} : raw;
    end else begin
      raw = {1'b0, a} + {1'b0, b} + {4'h0, cin};
      adj = raw + `ALU_BCD_ADJUST;
      nibble_arith = (bcd && raw > `ALU_BCD_MAX) ? {1'b1, adj[3:0]} : raw;
    end
  endfunction

  assign mem_form = (req_i.form == form_mem_imm);
  assign a_op = mem_form ? req_i.mem_val : req_i.reg_val;
  assign b_op = mem_form ? req_i.imm_val : req_i.mem_val;
  assign is_arith = req_i.valid && (req_i.op == op_add || req_i.op == op_add_with_carry ||
                    req_i.op == op_subtract || req_i.op == op_subtract_with_borrow);
  assign is_sub = (req_i.op == op_subtract) || (req_i.op == op_subtract_with_borrow);
  assign use_carry = (req_i.op == op_add_with_carry) || (req_i.op == op_subtract_with_borrow);
  assign arith_out = nibble_arith(a_op, b_op, use_carry & carry_q, is_sub, decimal_q);
  assign cmp_out = nibble_arith(req_i.mem_val, req_i.imm_val, 1'b0, 1'b1, 1'b0);
  assign rot_out = {carry_q, req_i.reg_val[3:1]};
  assign arith_zero = (arith_out[3:0] == `ALU_NIBBLE_ZERO);
  assign wr_status = sysreg_i.we && (sysreg_i.addr == `ALU_ADDR_STATUS);

  // zero flag update; an arithmetic operation outranks a software write.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      zero_q <= `ALU_FLAG_RESET;
    end else if (is_arith) begin
      zero_q <= compare_q ? (zero_q & arith_zero) : arith_zero;
    end else if (wr_status) begin
      zero_q <= sysreg_i.wdata[`ALU_BIT_ZERO];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      carry_q <= `ALU_FLAG_RESET;
    end else if (is_arith) begin
      carry_q <= arith_out[4];
    end else if (req_i.valid && req_i.op == op_rotate_right_through_carry) begin
      carry_q <= req_i.reg_val[0];
    end else if (wr_status) begin
      carry_q <= sysreg_i.wdata[`ALU_BIT_CARRY];
    end
  end

  // bit tests clear the compare flag.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      compare_q <= `ALU_FLAG_RESET;
    end else if (req_i.valid && (req_i.op == op_skip_if_bits_true || req_i.op == op_skip_if_bits_false)) begin
      compare_q <= 1'b0;
    end else if (wr_status) begin
      compare_q <= sysreg_i.wdata[`ALU_BIT_COMPARE];
    end
  end

  // decimal and index flags change only by software.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      decimal_q <= `ALU_FLAG_RESET;
      index_q <= `ALU_FLAG_RESET;
    end else begin
      if (sysreg_i.we && sysreg_i.addr == `ALU_ADDR_DECIMAL) begin
        decimal_q <= sysreg_i.wdata[`ALU_BIT_DECIMAL];
      end
      if (wr_status) begin
        index_q <= sysreg_i.wdata[`ALU_BIT_INDEX];
      end
    end
  end

  // status nibble layout on reads; unmapped reads give zero.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rdata_q <= `ALU_NIBBLE_ZERO;
    end else if (sysreg_i.re && sysreg_i.addr == `ALU_ADDR_STATUS) begin
      rdata_q <= {compare_q, carry_q, zero_q, index_q};
    end else if (sysreg_i.re && sysreg_i.addr == `ALU_ADDR_DECIMAL) begin
      rdata_q <= {3'h0, decimal_q};
    end else begin
      rdata_q <= `ALU_NIBBLE_ZERO;
    end
  end

  // Result and destination; handles every operation in one cycle.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      res_q <= '0;
    end else begin
      res_q <= '0;
      res_q.valid <= req_i.valid;
      if (req_i.valid) begin
        case (req_i.op)
          // stores blocked while compare is set.
          op_add, op_add_with_carry, op_subtract, op_subtract_with_borrow: begin
            res_q.data <= arith_out[3:0];
            res_q.reg_we <= !compare_q && !mem_form;
            res_q.mem_we <= !compare_q && mem_form;
          end
          op_or: begin
            res_q.data <= a_op | b_op;
            res_q.reg_we <= !mem_form;
            res_q.mem_we <= mem_form;
          end
          op_and: begin
            res_q.data <= a_op & b_op;
            res_q.reg_we <= !mem_form;
            res_q.mem_we <= mem_form;
          end
          op_xor: begin
            res_q.data <= a_op ^ b_op;
            res_q.reg_we <= !mem_form;
            res_q.mem_we <= mem_form;
          end
          op_skip_if_bits_true: res_q.skip <= ((req_i.mem_val & req_i.imm_val) == req_i.imm_val);
          op_skip_if_bits_false: res_q.skip <= ((req_i.mem_val & req_i.imm_val) == `ALU_NIBBLE_ZERO);
          op_skip_if_equal: res_q.skip <= (cmp_out[3:0] == `ALU_NIBBLE_ZERO);
          op_skip_if_unequal: res_q.skip <= (cmp_out[3:0] != `ALU_NIBBLE_ZERO);
          op_skip_if_greater_equal: res_q.skip <= !cmp_out[4];
          op_skip_if_less: res_q.skip <= cmp_out[4];
          op_rotate_right_through_carry: begin
            res_q.data <= rot_out;
            res_q.reg_we <= 1'b1;
          end
          default: res_q.valid <= req_i.valid;
        endcase
      end
    end
  end

  // single skip output from the result register.
  assign res_o = res_q;
  assign sysreg_rdata_o = rdata_q;
  assign index_enable_o = index_q;

  // Arithmetic results, destinations and carries.
  a_add_sum: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    req_i.valid && req_i.op == op_add && !decimal_q && !compare_q
    |=> res_o.data == 4'($past(a_op) + $past(b_op)) && (res_o.reg_we ^ res_o.mem_we))
    else $error("add result wrong");
  a_operand_form: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    req_i.valid && req_i.op == op_add && req_i.form == form_mem_imm && !decimal_q
    |=> res_o.data == 4'($past(req_i.mem_val) + $past(req_i.imm_val)))
    else $error("immediate operand not used");
  a_carry_out: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    req_i.valid && req_i.op == op_add && !decimal_q
    |=> carry_q == ($past({1'b0, a_op}) + $past({1'b0, b_op}) > 5'h0f))
    else $error("carry out wrong");
  a_add_with_carry_sum: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    req_i.valid && req_i.op == op_add_with_carry && !decimal_q
    |=> res_o.data == 4'($past(a_op) + $past(b_op) + $past(carry_q)))
    else $error("add with carry wrong");
  a_sub_diff: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    req_i.valid && req_i.op == op_subtract && !decimal_q
    |=> res_o.data == 4'($past(a_op) - $past(b_op)) && carry_q == ($past(a_op) < $past(b_op)))
    else $error("subtract wrong");
  a_subtract_with_borrow_diff: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    req_i.valid && req_i.op == op_subtract_with_borrow && !decimal_q
    |=> res_o.data == 4'($past(a_op) - $past(b_op) - $past(carry_q)))
    else $error("subtract with borrow wrong");
  a_dest_form: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    is_arith && !compare_q
    |=> res_o.mem_we == $past(mem_form) && res_o.reg_we == !$past(mem_form))
    else $error("arithmetic destination wrong");
  a_bcd_digit: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    is_arith && decimal_q && a_op <= 4'h9 && b_op <= 4'h9 && !compare_q
    |=> res_o.data <= 4'h9)
    else $error("decimal digit invalid");
  a_bcd_carry: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    req_i.valid && req_i.op == op_add && decimal_q && a_op <= 4'h9 && b_op <= 4'h9
    |=> carry_q == (5'($past(a_op)) + 5'($past(b_op)) > 5'h09))
    else $error("decimal carry wrong");

  // Status flags and the register port.
  a_zero_follow: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    is_arith && !compare_q
    |=> zero_q == (res_o.data == 4'h0))
    else $error("zero flag wrong");
  a_zero_hold: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    is_arith && compare_q && !zero_q
    |=> !zero_q)
    else $error("zero flag set under compare");
  a_zero_clear: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    is_arith && compare_q && !arith_zero
    |=> !zero_q)
    else $error("zero flag kept on non-zero result");
  a_cmp_nostore: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    is_arith && compare_q
    |=> !res_o.reg_we && !res_o.mem_we)
    else $error("store while compare set");
  a_logic_store: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    req_i.valid && (req_i.op == op_or || req_i.op == op_and || req_i.op == op_xor) && compare_q
    |=> res_o.reg_we ^ res_o.mem_we)
    else $error("logic store blocked by compare");
  a_status_read: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    sysreg_i.re && sysreg_i.addr == `ALU_ADDR_STATUS
    |=> sysreg_rdata_o == {$past(compare_q), $past(carry_q), $past(zero_q), $past(index_q)})
    else $error("status read wrong");
  a_status_write: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    wr_status && !req_i.valid
    |=> {compare_q, carry_q, zero_q, index_q} == $past(sysreg_i.wdata))
    else $error("status write lost");
  a_decimal_read: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    sysreg_i.re && sysreg_i.addr == `ALU_ADDR_DECIMAL
    |=> sysreg_rdata_o == {3'h0, $past(decimal_q)})
    else $error("decimal read wrong");
  a_decimal_keep: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !(sysreg_i.we && sysreg_i.addr == `ALU_ADDR_DECIMAL)
    |=> $stable(decimal_q))
    else $error("decimal flag changed");

  // Logical operations.
  a_or_bits: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    req_i.valid && req_i.op == op_or && req_i.form == form_reg_mem
    |=> res_o.data == ($past(req_i.reg_val) | $past(req_i.mem_val)) && res_o.reg_we && !res_o.mem_we)
    else $error("or result wrong");
  a_and_bits: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    req_i.valid && req_i.op == op_and && req_i.form == form_mem_imm
    |=> res_o.data == ($past(req_i.mem_val) & $past(req_i.imm_val)) && res_o.mem_we && !res_o.reg_we)
    else $error("and result wrong");
  a_xor_bits: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    req_i.valid && req_i.op == op_xor
    |=> res_o.data == ($past(a_op) ^ $past(b_op)))
    else $error("xor result wrong");
  a_logic_flags: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    req_i.valid && req_i.op == op_xor && !sysreg_i.we
    |=> $stable(carry_q) && $stable(zero_q) && $stable(decimal_q))
    else $error("logic op changed flags");

  // Bit tests and comparisons.
  a_bits_clear: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    req_i.valid && req_i.op == op_skip_if_bits_true
    |=> !compare_q && !res_o.reg_we && !res_o.mem_we)
    else $error("bit test side effects");
  a_true_skip: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    req_i.valid && req_i.op == op_skip_if_bits_true
    |=> res_o.skip == (($past(req_i.mem_val) & $past(req_i.imm_val)) == $past(req_i.imm_val)))
    else $error("bits true skip wrong");
  a_false_skip: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    req_i.valid && req_i.op == op_skip_if_bits_false
    |=> !compare_q && !res_o.reg_we && !res_o.mem_we
    && res_o.skip == (($past(req_i.mem_val) & $past(req_i.imm_val)) == 4'h0))
    else $error("bits false test wrong");
  a_equal_skip: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    req_i.valid && req_i.op == op_skip_if_equal
    |=> res_o.skip == ($past(req_i.mem_val) == $past(req_i.imm_val)))
    else $error("equal compare wrong");
  a_unequal_skip: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    req_i.valid && req_i.op == op_skip_if_unequal
    |=> res_o.skip == ($past(req_i.mem_val) != $past(req_i.imm_val)))
    else $error("unequal compare wrong");
  a_ge_skip: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    req_i.valid && req_i.op == op_skip_if_greater_equal
    |=> res_o.skip == ($past(req_i.mem_val) >= $past(req_i.imm_val)))
    else $error("greater equal compare wrong");
  a_less_skip: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    req_i.valid && req_i.op == op_skip_if_less
    |=> res_o.skip == ($past(req_i.mem_val) < $past(req_i.imm_val)))
    else $error("less compare wrong");
  a_judge_flags: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    req_i.valid && req_i.op >= op_skip_if_equal && req_i.op <= op_skip_if_less && !sysreg_i.we
    |=> $stable(carry_q) && $stable(zero_q) && $stable(compare_q) && !res_o.reg_we && !res_o.mem_we)
    else $error("comparison changed state");

  // Rotation and the skip output.
  a_rotate_bits: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    req_i.valid && req_i.op == op_rotate_right_through_carry
    |=> res_o.data == {$past(carry_q), $past(req_i.reg_val[3:1])} && carry_q == $past(req_i.reg_val[0]))
    else $error("rotate wrong");
  a_rotate_store: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    req_i.valid && req_i.op == op_rotate_right_through_carry
    |=> res_o.reg_we && !res_o.mem_we && !res_o.skip)
    else $error("rotate destination wrong");
  a_rotate_flags: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    req_i.valid && req_i.op == op_rotate_right_through_carry && !sysreg_i.we
    |=> $stable(zero_q) && $stable(compare_q) && $stable(decimal_q))
    else $error("rotate changed other flags");
  a_skip_only: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    res_o.skip
    |-> $past(req_i.valid) && $past(req_i.op) >= op_skip_if_bits_true
    && $past(req_i.op) <= op_skip_if_less)
    else $error("stray skip");
  a_idle_quiet: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !req_i.valid
    |=> res_o == '0)
    else $error("answer without request");

  c_bcd_add: cover property (@(posedge core_clk_i) is_arith && decimal_q && arith_out[4]);
  c_skip_taken: cover property (@(posedge core_clk_i) res_o.skip);
  c_cmp_block: cover property (@(posedge core_clk_i) is_arith && compare_q);
  c_rotate: cover property (@(posedge core_clk_i) req_i.valid && req_i.op == op_rotate_right_through_carry);
  c_sub_borrow: cover property (@(posedge core_clk_i) is_arith && is_sub && arith_out[4]);
endmodule

/* File: common/nibble_alu_defines.svh */
// Purpose: Addresses, flag positions and reset values of the nibble ALU.
// Assumes: Seven-bit system-register address seen on the register port.
// Notes: Included by bare name from the design and the bench.
`ifndef NIBBLE_ALU_DEFINES_SVH
`define NIBBLE_ALU_DEFINES_SVH
`define ALU_ADDR_W 7
`define ALU_ADDR_DECIMAL 7'h7e
`define ALU_ADDR_STATUS 7'h7f
`define ALU_BIT_DECIMAL 0
`define ALU_BIT_INDEX 0
`define ALU_BIT_ZERO 1
`define ALU_BIT_CARRY 2
`define ALU_BIT_COMPARE 3
`define ALU_FLAG_RESET 1'b0
`define ALU_NIBBLE_ZERO 4'h0
`define ALU_BCD_MAX 5'h09
`define ALU_BCD_ADJUST 5'h06
`endif

/* File: common/nibble_alu_pkg.sv */
// Purpose: Types shared by the nibble ALU and its users.
// Assumes: Operations arrive one per cycle from the instruction decoder.
// Notes: Constants live in nibble_alu_defines.svh.
package nibble_alu_pkg;
  typedef enum logic [3:0] {
    op_none = 4'h0,
    op_add = 4'h1,
    op_add_with_carry = 4'h2,
    op_subtract = 4'h3,
    op_subtract_with_borrow = 4'h4,
    op_or = 4'h5,
    op_and = 4'h6,
    op_xor = 4'h7,
    op_skip_if_bits_true = 4'h8,
    op_skip_if_bits_false = 4'h9,
    op_skip_if_equal = 4'ha,
    op_skip_if_unequal = 4'hb,
    op_skip_if_greater_equal = 4'hc,
    op_skip_if_less = 4'hd,
    op_rotate_right_through_carry = 4'he
  } alu_op_t;

  typedef enum logic {
    form_reg_mem = 1'b0,
    form_mem_imm = 1'b1
  } alu_form_t;

  typedef struct packed {
    logic valid;
    alu_op_t op;
    alu_form_t form;
    logic [3:0] reg_val;
    logic [3:0] mem_val;
    logic [3:0] imm_val;
  } alu_req_t;

  typedef struct packed {
    logic valid;
    logic reg_we;
    logic mem_we;
    logic [3:0] data;
    logic skip;
  } alu_res_t;

  typedef struct packed {
    logic [6:0] addr;
    logic [3:0] wdata;
    logic we;
    logic re;
  } sysreg_req_t;
endpackage

/* File: tb/alu_far_side.sv */
// Purpose: Far-side model of the general register and one data-memory nibble.
// Assumes: Store requests in the ALU answer are one-cycle pulses.
// Notes: Keeps only what the ALU asks to be stored.
`timescale 1ns/1ps
module alu_far_side (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input nibble_alu_pkg::alu_res_t res_i,
  output logic [3:0] gen_reg_o,
  output logic [3:0] mem_o
);
  import nibble_alu_pkg::*;
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      gen_reg_o <= 4'h0;
      mem_o <= 4'h0;
    end else if (res_i.valid) begin
      if (res_i.reg_we) gen_reg_o <= res_i.data;
      if (res_i.mem_we) mem_o <= res_i.data;
    end
  end
endmodule

/* File: tb/nibble_alu_with_status_flags_tb_top.sv */
// Purpose: Self-checking bench for the nibble ALU and its status nibbles.
// Assumes: One operation or register access at a time.
// Notes: Expected answers are worked out by hand per scenario.
`timescale 1ns/1ps
`include "nibble_alu_defines.svh"
module nibble_alu_with_status_flags_tb_top;
  import nibble_alu_pkg::*;
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  alu_req_t req = '0;
  sysreg_req_t sreg = '0;
  alu_res_t res;
  logic [3:0] rdata;
  logic [3:0] gen_reg;
  logic [3:0] mem;
  logic index_en;
  int n_fail = 0;
  int samples_checked = 0;
  nibble_alu dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .req_i(req), .res_o(res),
    .sysreg_i(sreg), .sysreg_rdata_o(rdata), .index_enable_o(index_en));
  alu_far_side far (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .res_i(res), .gen_reg_o(gen_reg), .mem_o(mem));
  initial begin
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [3:0] d);
    @(posedge core_clk_i);
    sreg <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge core_clk_i);
    sreg <= '0;
  endtask
  task automatic rd(input logic [6:0] a, input logic [3:0] e, input string name);
    @(posedge core_clk_i);
    sreg <= '{addr: a, wdata: 4'h0, we: 1'b0, re: 1'b1};
    @(posedge core_clk_i);
    sreg <= '0;
    #1;
    chk(name, {4'h0, e}, {4'h0, rdata});
  endtask
  task automatic op(input alu_op_t o, input alu_form_t f, input logic [3:0] r, m, i);
    @(posedge core_clk_i);
    req <= '{valid: 1'b1, op: o, form: f, reg_val: r, mem_val: m, imm_val: i};
    @(posedge core_clk_i);
    req <= '0;
    #1;
  endtask
  task automatic t_reset();
    rd(`ALU_ADDR_STATUS, 4'h0, "status_rst");
    rd(`ALU_ADDR_DECIMAL, 4'h0, "decimal_rst");
    rd(7'h12, 4'h0, "unmapped");
    op(op_none, form_reg_mem, 4'h3, 4'h3, 4'h3);
    chk("none", 8'h80, res);
    $display("test reset done");
  endtask
  task automatic t_binary();
    op(op_add, form_reg_mem, 4'h9, 4'h7, 4'h0);
    chk("add", 8'hc0, res);
    rd(`ALU_ADDR_STATUS, 4'h6, "add_flags");
    op(op_add_with_carry, form_mem_imm, 4'h0, 4'h2, 4'h3);
    chk("add_with_carry", 8'hac, res);
    rd(`ALU_ADDR_STATUS, 4'h0, "add_with_carry_flags");
    op(op_subtract, form_reg_mem, 4'h2, 4'h5, 4'h0);
    chk("sub", 8'hda, res);
    rd(`ALU_ADDR_STATUS, 4'h4, "sub_flags");
    op(op_subtract_with_borrow, form_mem_imm, 4'h0, 4'h8, 4'h2);
    chk("subtract_with_borrow", 8'haa, res);
    $display("test binary done");
  endtask
  task automatic t_decimal();
    wr(`ALU_ADDR_DECIMAL, 4'h1);
    rd(`ALU_ADDR_DECIMAL, 4'h1, "decimal_rw");
    op(op_add, form_reg_mem, 4'h8, 4'h5, 4'h0);
    chk("bcd_add", 8'hc6, res);
    rd(`ALU_ADDR_STATUS, 4'h4, "bcd_carry");
    op(op_subtract, form_mem_imm, 4'h0, 4'h3, 4'h5);
    chk("bcd_sub", 8'hb0, res);
    @(posedge core_clk_i);
    #1;
    chk("mem_stored", 8'h08, {4'h0, mem});
    wr(`ALU_ADDR_DECIMAL, 4'h0);
    $display("test decimal done");
  endtask
  task automatic t_compare();
    wr(`ALU_ADDR_STATUS, 4'hf);
    op(op_add, form_mem_imm, 4'h0, 4'h0, 4'h0);
    chk("cmp_nostore", 8'h0, {6'h0, res.reg_we, res.mem_we});
    rd(`ALU_ADDR_STATUS, 4'hb, "cmp_zero_keep");
    chk("index", 8'h1, {7'h0, index_en});
    op(op_add, form_reg_mem, 4'h1, 4'h1, 4'h0);
    rd(`ALU_ADDR_STATUS, 4'h9, "cmp_zero_clr");
    chk("mem_kept", 8'h08, {4'h0, mem});
    op(op_or, form_reg_mem, 4'h5, 4'ha, 4'h0);
    chk("or", 8'hde, res);
    op(op_and, form_mem_imm, 4'h0, 4'hc, 4'h6);
    chk("and", 8'ha8, res);
    op(op_xor, form_mem_imm, 4'h0, 4'hc, 4'h6);
    chk("xor", 8'hb4, res);
    rd(`ALU_ADDR_STATUS, 4'h9, "logic_flags");
    $display("test compare done");
  endtask
  task automatic t_judge();
    alu_op_t ops [4] = '{op_skip_if_equal, op_skip_if_unequal, op_skip_if_greater_equal, op_skip_if_less};
    op(op_skip_if_bits_true, form_mem_imm, 4'h0, 4'hb, 4'h3);
    chk("bits_true", 8'h1, {5'h0, res.reg_we, res.mem_we, res.skip});
    rd(`ALU_ADDR_STATUS, 4'h1, "cmp_cleared");
    op(op_skip_if_bits_true, form_mem_imm, 4'h0, 4'hb, 4'h4);
    chk("bits_true_no", 8'h0, {7'h0, res.skip});
    op(op_skip_if_bits_false, form_mem_imm, 4'h0, 4'hb, 4'h4);
    chk("bits_false", 8'h1, {5'h0, res.reg_we, res.mem_we, res.skip});
    op(op_skip_if_bits_false, form_mem_imm, 4'h0, 4'hb, 4'h2);
    chk("bits_false_no", 8'h0, {7'h0, res.skip});
    for (int k = 0; k < 4; k++) begin
      op(ops[k], form_mem_imm, 4'h0, 4'h5, 4'h5);
      chk("cmp_same", {7'h0, ~k[0]}, {5'h0, res.reg_we, res.mem_we, res.skip});
      op(ops[k], form_mem_imm, 4'h0, 4'h3, 4'h5);
      chk("cmp_below", {7'h0, k[0]}, {5'h0, res.reg_we, res.mem_we, res.skip});
    end
    rd(`ALU_ADDR_STATUS, 4'h1, "judge_flags");
    $display("test judge done");
  endtask
  task automatic t_rotate();
    wr(`ALU_ADDR_STATUS, 4'h4);
    op(op_rotate_right_through_carry, form_reg_mem, 4'h6, 4'h0, 4'h0);
    chk("rot_a", 8'hd6, res);
    rd(`ALU_ADDR_STATUS, 4'h0, "rot_a_cy");
    op(op_rotate_right_through_carry, form_reg_mem, 4'hb, 4'h0, 4'h0);
    chk("rot_b", 8'hca, res);
    rd(`ALU_ADDR_STATUS, 4'h4, "rot_b_cy");
    chk("reg_stored", 8'h05, {4'h0, gen_reg});
    $display("test rotate done");
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    n_fail++;
    complete_run();
  end
  initial begin
    repeat (6) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_binary();
    t_decimal();
    t_compare();
    t_judge();
    t_rotate();
    complete_run();
  end
endmodule
